// >>> src/gpio_port_a.sv
// Controller GPIO port group A: registers, pin drivers, wake detect
`timescale 1ns/1ps
`default_nettype none
module controller_gpio_port_group_a
  import gpio_port_a_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Controller register access
  input  wire logic [15:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wdata,
  output var  logic [7:0]  o_rdata,
  // Configuration
  input  wire logic [15:0] i_wake_edge,
  input  wire logic [7:0]  i_alt_sel,
  input  wire logic [7:0]  i_alt_out,
  input  wire logic        i_external_interrupt_one_enable,
  input  wire logic        i_pin7_open_drain,
  input  wire logic        i_main_power_good,
  // Pins
  input  wire logic [7:0]  i_pin,
  output var  logic [7:0]  o_pin,
  output var  logic [7:0]  o_pin_oe,
  // Events
  output var  logic [7:0]  o_wake,
  output var  logic        o_external_interrupt_one
);
  // Timing at a glance, counted in clock edges:
  //   write strobe at edge n, pin drive follows at edge n+1
  //   read strobe at edge n, read data stands from edge n
  //   a pin change reaches the input register two edges later
  //   a pin edge shows as a one-cycle wake pulse three edges later
  //   reset drops every drive enable at once, no clock needed
  // Limitations:
  //   pulses shorter than a clock period may be missed by wake
  //   configuration ports are taken from logic on this clock
  //   power good is a pin and goes through its own synchroniser
  //   an alternate function keeps the wake events of its pin
  // Trade-off: two sync stages cost latency but stop metastable reads

  // Registered state and the value it takes at the next edge
  gpio_state_t s_q;
  gpio_state_t s_d;

  // Address match for one register; shared by write and read decode
  function automatic logic addr_hit(input logic [15:0] addr,
                                    input logic [15:0] target);
    addr_hit = (addr == target);
  endfunction

  // Register write: new byte on a matching strobe, else keep the old
  // Writes to the input register or unmapped space fall through here
  function automatic logic [7:0] write_byte(input logic        wr,
                                            input logic [15:0] addr,
                                            input logic [15:0] target,
                                            input logic [7:0]  old_val,
                                            input logic [7:0]  new_val);
    if (wr && addr_hit(addr, target)) begin
      write_byte = new_val;
    end else begin
      write_byte = old_val;
    end
  endfunction

  // Read mux; unmapped addresses return zero rather than stale data
  function automatic logic [7:0] read_mux(input logic [15:0] addr,
                                          input logic [7:0]  dir,
                                          input logic [7:0]  outv,
                                          input logic [7:0]  sensed);
    if (addr_hit(addr, ADDR_DIRECTION)) begin
      read_mux = dir;
    end else if (addr_hit(addr, ADDR_OUTPUT_VALUE)) begin
      read_mux = outv;
    end else if (addr_hit(addr, ADDR_INPUT)) begin
      read_mux = sensed;
    end else begin
      read_mux = RST_ZERO;
    end
  endfunction

  // Edge match per pin for the selected trigger
  // Code 3 lands in the default arm and never matches: wake off
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       p,
                                    input logic       c);
    case (sel)
      EDGE_RISE: edge_hit = !p && c;
      EDGE_FALL: edge_hit = p && !c;
      EDGE_BOTH: edge_hit = p ^ c;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  // Wake event for one pin; pins that cannot wake stay silent
  function automatic logic wake_hit(input int         pin,
                                    input logic [1:0] sel,
                                    input logic       p,
                                    input logic       c);
    wake_hit = WAKE_CAPABLE[pin] && edge_hit(sel, p, c);
  endfunction

  // Level offered to a pin: alternate function or output register
  function automatic logic pin_level(input logic alt,
                                     input logic alt_level,
                                     input logic gpio_level);
    pin_level = alt ? alt_level : gpio_level;
  endfunction

  // Drive enable of a pin serving its alternate function
  // GPIO-default pins borrow the direction bit; others drive unless the back-bias check floats them
  function automatic logic alt_drive(input int   pin,
                                     input logic dir_bit,
                                     input logic power_ok);
    logic drv;
    drv = NON_GPIO_DEFAULT[pin] ? 1'b1 : dir_bit;
    // Floating keeps unpowered circuitry from being back-biased
    if (BACKBIAS_SET[pin] && !power_ok) begin
      drv = 1'b0;
    end
    alt_drive = drv;
  endfunction

  // Drive enable of a pin in plain GPIO use
  // Open drain on one pin only: a high level releases the pin
  function automatic logic gpio_drive(input int   pin,
                                      input logic dir_bit,
                                      input logic level,
                                      input logic open_drain);
    logic drv;
    drv = dir_bit;
    if (pin == OD_PIN && open_drain && level) begin
      drv = 1'b0;
    end
    gpio_drive = drv;
  endfunction

  // Drive enable of one pin for whichever function owns it
  function automatic logic drive_enable(input int   pin,
                                        input logic alt,
                                        input logic dir_bit,
                                        input logic level,
                                        input logic open_drain,
                                        input logic power_ok);
    if (alt) begin
      drive_enable = alt_drive(pin, dir_bit, power_ok);
    end else begin
      drive_enable = gpio_drive(pin, dir_bit, level, open_drain);
    end
  endfunction

  // Next state: registers, synchronisers, drivers, wake
  always_comb begin
    // Hold everything by default; groups below override
    s_d = s_q;

    // Pin synchroniser; only the second stage feeds logic
    s_d.sync1 = i_pin;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;

    // Power good synchroniser; a slow rail edge must not split pins
    s_d.pg_sync1 = i_main_power_good;
    s_d.pg_sync2 = s_q.pg_sync1;

    // Direction write
    s_d.dir = write_byte(i_wr, i_addr, ADDR_DIRECTION,
                         s_q.dir, i_wdata);

    // Output value write
    s_d.outv = write_byte(i_wr, i_addr, ADDR_OUTPUT_VALUE,
                          s_q.outv, i_wdata);

    // Read data held until the next read strobe
    if (i_rd) begin
      s_d.rdata = read_mux(i_addr, s_q.dir, s_q.outv,
                           s_q.sync2);
    end

    // Per pin: wake detect, then level and drive enable
    for (int i = 0; i < 8; i++) begin
      // Wake sees the pin whatever function is selected
      s_d.wake[i]    = wake_hit(i, i_wake_edge[2*i +: 2],
                                s_q.prev[i], s_q.sync2[i]);
      // Level and enable; both change on the same edge
      s_d.pin_out[i] = pin_level(i_alt_sel[i], i_alt_out[i],
                                 s_q.outv[i]);
      s_d.pin_oe[i]  = drive_enable(i, i_alt_sel[i], s_q.dir[i],
                                    s_q.outv[i], i_pin7_open_drain,
                                    s_q.pg_sync2);
    end

    // Pin 3 straight to the interrupt input: synced level, no edge
    s_d.irq1 = i_external_interrupt_one_enable && s_q.sync2[INT_PIN];
  end

  // State register; reset to constants only
  // Asynchronous reset floats every pin before the clock runs
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_q      <= '0;
      s_q.dir  <= RST_DIRECTION;
      s_q.outv <= RST_OUTPUT_VALUE;
    end else begin
      s_q <= s_d;
    end
  end

  // Register read port
  assign o_rdata = s_q.rdata;

  // Pin drivers
  assign o_pin    = s_q.pin_out;
  assign o_pin_oe = s_q.pin_oe;

  // Events
  assign o_wake                   = s_q.wake;
  assign o_external_interrupt_one = s_q.irq1;
endmodule // controller_gpio_port_group_a
`default_nettype wire

// >>> src/gpio_port_a_pkg.sv
// Constants and types for the controller GPIO port group A
// What this block does
// - A direction register at 0x7f18 holds one bit per pin, one means output, and resets to zero.
// - An output value register at 0x7f19 holds the level to drive on each pin, readable and writable, reset zero.
// - Each wake-capable pin selects a rising, falling or either-edge wake trigger.
// - Wake events still come from a wake-capable pin while it serves an alternate function.
// - While main power is not good, pins in the back-bias set acting as alternate outputs float.
// - On a GPIO-default pin the direction bit also sets the direction of its alternate function.
// - On a pin whose default is not GPIO the direction bit does not steer the default function.
// - Pin 3 can be routed straight to external interrupt one and is not wake-capable.
// - Pin 7 drives push-pull or open-drain by choice, pins 0-6 push-pull only, only in GPIO use.
// - A read-only input register at 0x7f1a returns the sensed level of every pin.
package gpio_port_a_pkg;
  localparam logic [15:0] ADDR_DIRECTION    = 16'h7f18;
  localparam logic [15:0] ADDR_OUTPUT_VALUE = 16'h7f19;
  localparam logic [15:0] ADDR_INPUT        = 16'h7f1a;
  localparam logic [7:0]  RST_DIRECTION     = 8'h00;
  localparam logic [7:0]  RST_OUTPUT_VALUE  = 8'h00;
  localparam logic [7:0]  RST_ZERO          = 8'h00;
  // Pins able to wake: all but pin 3
  localparam logic [7:0]  WAKE_CAPABLE      = 8'hf7;
  localparam int          INT_PIN           = 3;
  localparam int          OD_PIN            = 7;
  // No pin of this group sits in the back-bias set; kept for reuse
  localparam logic [7:0]  BACKBIAS_SET      = 8'h00;
  // Pins whose default function is not GPIO: none here
  localparam logic [7:0]  NON_GPIO_DEFAULT  = 8'h00;
  // Wake edge select codes
  localparam logic [1:0]  EDGE_RISE         = 2'h0;
  localparam logic [1:0]  EDGE_FALL         = 2'h1;
  localparam logic [1:0]  EDGE_BOTH         = 2'h2;

  typedef struct packed {
    logic [7:0]  dir;
    logic [7:0]  outv;
    logic [7:0]  rdata;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  prev;
    logic [7:0]  wake;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic        irq1;
    logic        pg_sync1;
    logic        pg_sync2;
  } gpio_state_t;
endpackage

// >>> test/gpio_a_board.sv
// Board model on the port pins: pull-ups and an external driver
`timescale 1ns/1ps
`default_nettype none
module gpio_a_board (input wire logic [7:0] i_out, i_oe, i_ext, i_ext_oe,
  output var logic [7:0] o_level);
  // Released pins rest high; a pull-up also lifts open drain
  assign o_level = i_oe & i_out | ~i_oe & ~(i_ext_oe & ~i_ext);
endmodule // gpio_a_board
`default_nettype wire

// >>> test/gpio_a_chk.sv
// Assertions on the GPIO port group A ports
`timescale 1ns/1ps
`default_nettype none
module gpio_a_chk import gpio_port_a_pkg::*; (
  // Clock, reset and register strobes
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [7:0]  i_wdata,
  // Configuration
  input wire logic        i_pin7_open_drain,
  input wire logic        i_external_interrupt_one_enable,
  input wire logic [7:0]  i_alt_sel,
  input wire logic [15:0] i_wake_edge,
  // Design outputs
  input wire logic        o_external_interrupt_one,
  input wire logic [7:0]  o_pin,
  input wire logic [7:0]  o_pin_oe,
  input wire logic [7:0]  o_wake
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Direction lands one edge after the write, drive one edge later
  property p_off; i_wr && i_addr == ADDR_DIRECTION && i_wdata == 8'h00
    |-> ##2 o_pin_oe == 8'h00; endproperty
  a_off: assert property (p_off) else $error("oe");
  property p_od; o_pin_oe[7] && o_pin[7] && !$past(i_alt_sel[7])
    |-> !$past(i_pin7_open_drain); endproperty
  a_od: assert property (p_od) else $error("od");
  property p_irq; o_external_interrupt_one
    |-> $past(i_external_interrupt_one_enable); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  // Two rises in a row need a fall between them
  property p_rise_once;
    o_wake[0] && $past(i_wake_edge[1:0]) == EDGE_RISE &&
      i_wake_edge[1:0] == EDGE_RISE |=> !o_wake[0];
  endproperty
  a_rise_once: assert property (p_rise_once) else $error("rise");
  property p_wake_off;
    $past(i_wake_edge[9:8]) == 2'h3 |-> !o_wake[4];
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake off");
  property p_no_wake3;
    !o_wake[3];
  endproperty
  a_no_wake3: assert property (p_no_wake3) else $error("wake 3");
endmodule // gpio_a_chk
bind controller_gpio_port_group_a gpio_a_chk chk (.*);
`default_nettype wire

// >>> test/controller_gpio_port_group_a_tb_top.sv
// Bench for GPIO port group A
`timescale 1ns/1ps
`default_nettype none
module controller_gpio_port_group_a_tb_top import gpio_port_a_pkg::*;;
  logic i_mclk = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
  logic i_external_interrupt_one_enable = 1'h0, i_pin7_open_drain = 1'h0;
  logic [15:0] i_addr = 16'h0;
  logic [7:0] i_wdata = 8'h0, i_alt_sel = 8'h0, ext = 8'h0, eoe = 8'h0;
  wire logic [7:0] o_rdata, o_pin, o_pin_oe, o_wake, i_pin;
  wire logic o_external_interrupt_one;
  int failures = 0, n_tests = 0;
  always #2 i_mclk = ~i_mclk;
  // Wake codes: pin0 rise, pin1 fall, pin2 both, pin4 off, pins 5-7 rise
  controller_gpio_port_group_a DUT (.*, .i_alt_out(i_alt_sel),
    .i_wake_edge(16'h03e4), .i_main_power_good(1'h0));
  gpio_a_board board (.i_out(o_pin), .i_oe(o_pin_oe), .i_ext(ext),
    .i_ext_oe(eoe), .o_level(i_pin));
  task automatic chk(string n, logic [7:0] s, e);
    n_tests++;
    if (s !== e) $display("Error %s exp %h seen %h", n, e, s);
    failures += (s !== e);
  endtask
  // One strobe cycle; reads are checked once the data has landed
  task automatic io(logic [15:0] x, logic w, logic [7:0] v);
    repeat (3) @(negedge i_mclk);
    {i_addr, i_wdata, i_wr, i_rd} = {x, v, w, !w};
    @(negedge i_mclk);
    {i_wr, i_rd} = 2'h0;
    if (!w) @(negedge i_mclk) chk("rdata", o_rdata, v);
  endtask
  task automatic col(logic [7:0] e);
    logic [7:0] acc = 8'h0;
    repeat (8) @(negedge i_mclk) acc |= o_wake;
    chk("wake", acc, e);
  endtask
  task automatic finish_test;
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge i_mclk);
    i_rst = 1'h0;
    io(ADDR_OUTPUT_VALUE, 1'h1, 8'hda);
    io(ADDR_INPUT, 1'h0, 8'hff);
    io(ADDR_DIRECTION, 1'h1, 8'hff);
    io(ADDR_INPUT, 1'h0, 8'hda);
    i_pin7_open_drain = 1'h1;
    io(ADDR_OUTPUT_VALUE, 1'h0, 8'hda);
    chk("oe", o_pin_oe, 8'h7f);
    {eoe, i_external_interrupt_one_enable} = 9'h1ff;
    io(ADDR_DIRECTION, 1'h1, 8'h00);
    i_alt_sel = 8'h20;
    col(8'h02);
    chk("irq", o_external_interrupt_one, 8'h00);
    ext = 8'hff;
    col(8'he5);
    chk("irq", o_external_interrupt_one, 8'h01);
    eoe = 8'h00;
    io(ADDR_DIRECTION, 1'h1, 8'h20);
    io(16'h0000, 1'h0, 8'h00);
    chk("alt", o_pin_oe & o_pin, 8'h20);
    finish_test();
  end
endmodule // controller_gpio_port_group_a_tb_top
`default_nettype wire
